// [hw/usr_pkg.sv]
// Package for the serial port block: register offsets, field positions,
// reset values and the bus and pin carriers.
// Assumes a single 20 MHz core clock and a plain strobe register port.
package usr_pkg;

  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] ADDR_IRQ_FLAGS   = 8'h0c;
  localparam logic [7:0] ADDR_RX_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_TX_BUFFER   = 8'h19;
  localparam logic [7:0] ADDR_RX_BUFFER   = 8'h1a;
  localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] ADDR_TX_STATUS   = 8'h98;
  localparam logic [7:0] ADDR_BAUD_DIV    = 8'h99;

  // Reset values
  localparam logic [7:0] RST_IRQ_FLAGS    = 8'h00;
  localparam logic [7:0] RST_RX_STATUS    = 8'h00;
  localparam logic [7:0] RST_TX_BUFFER    = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLES  = 8'h00;
  localparam logic [7:0] RST_TX_STATUS    = 8'h02;
  localparam logic [7:0] RST_BAUD_DIV     = 8'h00;

  // Flag and enable register fields
  localparam int BIT_TX_EMPTY      = 4;
  localparam int BIT_RX_AVAIL      = 5;
  // Receive status/control fields
  localparam int BIT_RX_NINTH      = 0;
  localparam int BIT_OVERRUN       = 1;
  localparam int BIT_FRAMING       = 2;
  localparam int BIT_CONT_RX_EN    = 4;
  localparam int BIT_SINGLE_RX_EN  = 5;
  localparam int BIT_NINE_RX_EN    = 6;
  localparam int BIT_PORT_EN       = 7;
  // Transmit status/control fields
  localparam int BIT_TX_NINTH      = 0;
  localparam int BIT_SHIFTER_EMPTY = 1;
  localparam int BIT_HIGH_SPEED    = 2;
  localparam int BIT_SYNC_MODE     = 4;
  localparam int BIT_TX_EN         = 5;
  localparam int BIT_NINE_TX_EN    = 6;
  localparam int BIT_CLK_MASTER    = 7;

  // Timing: oversample ticks per bit and generator prescales
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;  // x16 recovery
  localparam logic [3:0] SAMPLE_MID      = 4'h7;  // Centre of a bit
  localparam logic [1:0] PRE_FAST        = 2'h0;  // Fosc/16 per bit
  localparam logic [1:0] PRE_SLOW        = 2'h3;  // Fosc/64 per bit
  localparam logic [1:0] PRE_SYNC        = 2'h1;  // Fosc/4: two ticks per bit
  localparam logic [3:0] BITS_EIGHT      = 4'h9;  // Start + 8 data
  localparam logic [3:0] BITS_NINE       = 4'ha;  // Start + 9 data

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } usr_bus_req_t;

  // Pin drive group for one two-way pin
  typedef struct packed {
    logic o;
    logic oe;
  } usr_pin_t;

  // One receive FIFO entry: framing flag, ninth bit, data
  typedef struct packed {
    logic       framing;
    logic       ninth;
    logic [7:0] data;
  } usr_rx_word_t;

endpackage

// [hw/usr_top.sv]
// Serial port: asynchronous receiver with two-entry FIFO and synchronous
// master transmitter, behind a strobe register port.
// Assumes pins are outside the clock domain; the register master is not.
`timescale 1ns/1ps
module usr_top (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Register port
  input  wire usr_pkg::usr_bus_req_t bus_req,
  output logic [7:0]             bus_rdata,
  // Transmit-or-clock pin
  input  wire logic              transmit_or_clock_pin_i,
  output usr_pkg::usr_pin_t      transmit_or_clock_pin,
  // Receive-or-data pin
  input  wire logic              receive_or_data_pin_i,
  output usr_pkg::usr_pin_t      receive_or_data_pin,
  // Interrupt requests seen by the core
  output logic                   receive_irq,
  output logic                   transmit_irq
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usr_rx_state_t;

  typedef struct packed {
    logic [7:0]              irq_en;
    logic [7:0]              rx_ctl;      // Writable bits of receive control
    logic [7:0]              tx_ctl;      // Writable bits of transmit control
    logic [7:0]              baud_div;
    logic [7:0]              tx_buf;
    logic                    tx_buf_full;
    logic                    tx_empty_flag;
    logic                    overrun;
    usr_pkg::usr_rx_word_t [1:0] fifo;
    logic [1:0]              fifo_cnt;
    logic                    fifo_rd_ptr;
    logic [1:0]              rx_sync;     // Two-stage pin synchroniser
    logic [7:0]              brg_cnt;
    logic [1:0]              pre_cnt;
    logic [3:0]              os_cnt;
    usr_rx_state_t           rx_state;
    logic [3:0]              rx_bits;
    logic [8:0]              rx_shift;
    logic [9:0]              transmit_shift_register;         // Start + 9 data in async view
    logic [3:0]              tx_bits;
    logic                    tsr_busy;
    logic                    sclk;
    logic                    srx_active;  // Sync single-word receive in progress
    logic [3:0]              srx_bits;
    logic [7:0]              rdata;
    usr_pkg::usr_pin_t       ck_pin;
    usr_pkg::usr_pin_t       dt_pin;
  } usr_state_t;

  usr_state_t s;
  usr_state_t next_s;

  // Decode a register hit
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Fields pulled out for readability
  logic port_en;
  logic sync_mode;
  logic clk_master;
  logic tx_en;
  logic cont_rx;
  logic single_rx;
  logic rx_bit;
  assign port_en    = s.rx_ctl[usr_pkg::BIT_PORT_EN];
  assign sync_mode  = s.tx_ctl[usr_pkg::BIT_SYNC_MODE];
  assign clk_master = s.tx_ctl[usr_pkg::BIT_CLK_MASTER];
  assign tx_en      = s.tx_ctl[usr_pkg::BIT_TX_EN];
  assign cont_rx    = s.rx_ctl[usr_pkg::BIT_CONT_RX_EN];
  assign single_rx  = s.rx_ctl[usr_pkg::BIT_SINGLE_RX_EN];
  assign rx_bit     = s.rx_sync[1];

  always_comb begin
    logic brg_run;
    logic brg_tick;
    logic pre_tick;
    logic [1:0] pre_last;
    logic rx_mode;
    logic sclk_rise;
    logic sclk_fall;
    logic shift_on;
    logic push;
    logic pop;
    usr_pkg::usr_rx_word_t word;
    logic [7:0] tx_stat;
    logic [7:0] rx_stat;
    logic [7:0] flags;
    next_s = s;
    brg_run = 1'b0;
    brg_tick = 1'b0;
    pre_tick = 1'b0;
    pre_last = 2'h0;
    rx_mode = 1'b0;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    shift_on = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    word = '0;
    tx_stat = 8'h00;
    rx_stat = 8'h00;
    flags = 8'h00;
    next_s.rx_sync = {s.rx_sync[0], receive_or_data_pin_i};

    // Baud generator held reset while every enable is clear
    brg_run = tx_en | cont_rx | single_rx;
    if (!brg_run) begin
      next_s.brg_cnt = 8'h00;
      next_s.pre_cnt = 2'h0;
    end else if (s.brg_cnt == 8'h00) begin
      next_s.brg_cnt = s.baud_div;
      brg_tick = 1'b1;
    end else begin
      next_s.brg_cnt = s.brg_cnt - 8'h01;
    end
    // Prescale: sync /4 per bit, async x16 or x64 of bit rate
    if (sync_mode) begin
      pre_last = usr_pkg::PRE_SYNC;
    end else if (s.tx_ctl[usr_pkg::BIT_HIGH_SPEED]) begin
      pre_last = usr_pkg::PRE_FAST;
    end else begin
      pre_last = usr_pkg::PRE_SLOW;
    end
    if (brg_tick) begin
      if (s.pre_cnt >= pre_last) begin
        next_s.pre_cnt = 2'h0;
        pre_tick = 1'b1;
      end else begin
        next_s.pre_cnt = s.pre_cnt + 2'h1;
      end
    end

    // Half-duplex: any receive enable takes the port from the transmitter
    rx_mode = cont_rx | single_rx | s.srx_active;

    // Master shift clock: two ticks per bit, only while a word shifts; a high
    // clock finishes its half period, so an idle port parks it low
    shift_on = (s.tsr_busy & tx_en & ~rx_mode) | s.srx_active;
    if (sync_mode && port_en && clk_master && brg_run && pre_tick
        && (shift_on || s.sclk)) begin
      next_s.sclk = ~s.sclk;
      sclk_rise = ~s.sclk;
      sclk_fall = s.sclk;
    end else if (!brg_run) begin
      next_s.sclk = 1'b0;
    end

    // Async receiver, x16 oversampling, one shift per bit
    if (sync_mode || !cont_rx || !port_en) begin
      next_s.rx_state = RX_IDLE;
    end else if (pre_tick) begin
      next_s.os_cnt = s.os_cnt + 4'h1;
      case (s.rx_state)
        RX_IDLE: begin
          if (!rx_bit) begin
            next_s.rx_state = RX_START;
            next_s.os_cnt = 4'h0;
          end
        end
        RX_START: begin
          if (s.os_cnt == usr_pkg::SAMPLE_MID) begin
            next_s.os_cnt = 4'h0;
            next_s.rx_bits = 4'h0;
            next_s.rx_state = rx_bit ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (s.os_cnt == usr_pkg::OVERSAMPLE_LAST) begin
            next_s.rx_shift = {rx_bit, s.rx_shift[8:1]};
            next_s.rx_bits = s.rx_bits + 4'h1;
            if (s.rx_bits == (s.rx_ctl[usr_pkg::BIT_NINE_RX_EN] ? 4'h8 : 4'h7)) begin
              next_s.rx_state = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (s.os_cnt == usr_pkg::OVERSAMPLE_LAST) begin
            next_s.rx_state = RX_IDLE;
            word.framing = ~rx_bit;  // Low stop bit
            if (s.rx_ctl[usr_pkg::BIT_NINE_RX_EN]) begin
              word.ninth = s.rx_shift[8];
              word.data = s.rx_shift[7:0];
            end else begin
              word.ninth = 1'b0;
              word.data = s.rx_shift[8:1];
            end
            // Overrun blocks all transfers until the enable is cleared
            if (s.overrun) begin
              push = 1'b0;
            end else if (s.fifo_cnt == 2'h2) begin
              next_s.overrun = 1'b1;  // Word dropped
            end else begin
              push = 1'b1;            // Room left
            end
          end
        end
        default: next_s.rx_state = RX_IDLE;
      endcase
    end

    // Sync master single-word receive, sampled on falling edge
    if (!sync_mode || !single_rx || cont_rx) begin
      next_s.srx_active = 1'b0;
    end else if (!s.srx_active) begin
      next_s.srx_active = 1'b1;
      next_s.srx_bits = 4'h0;
    end else if (sclk_fall) begin
      next_s.rx_shift = {rx_bit, s.rx_shift[8:1]};
      next_s.srx_bits = s.srx_bits + 4'h1;
      if (s.srx_bits == (s.rx_ctl[usr_pkg::BIT_NINE_RX_EN] ? 4'h8 : 4'h7)) begin
        // Single enable drops after one word; transmit may resume
        next_s.srx_active = 1'b0;
        next_s.rx_ctl[usr_pkg::BIT_SINGLE_RX_EN] = 1'b0;
        word.framing = 1'b0;
        word.ninth = s.rx_ctl[usr_pkg::BIT_NINE_RX_EN] & rx_bit;
        word.data = s.rx_ctl[usr_pkg::BIT_NINE_RX_EN] ? s.rx_shift[8:1]
                                                        : {rx_bit, s.rx_shift[8:2]};
        if (s.overrun) begin
          push = 1'b0;
        end else if (s.fifo_cnt == 2'h2) begin
          next_s.overrun = 1'b1;
        end else begin
          push = 1'b1;
        end
      end
    end

    // Transmitter: reload only when empty
    if (!tx_en) begin
      next_s.tsr_busy = 1'b0;  // Abort and reset
      next_s.tx_bits = 4'h0;
    end else if (!s.tsr_busy && s.tx_buf_full) begin
      // Present ninth bit value loads with the data
      next_s.transmit_shift_register = {1'b0, s.tx_ctl[usr_pkg::BIT_TX_NINTH], s.tx_buf};
      next_s.tsr_busy = 1'b1;
      next_s.tx_bits = 4'h0;
      next_s.tx_buf_full = 1'b0;
      next_s.tx_empty_flag = 1'b1;  // Set regardless of its enable
    end else if (s.tsr_busy && sync_mode && sclk_rise && !rx_mode) begin
      // Each bit changes on the rising edge, stable at falling
      next_s.dt_pin.o = s.transmit_shift_register[0];
      next_s.transmit_shift_register = {1'b0, s.transmit_shift_register[9:1]};
      next_s.tx_bits = s.tx_bits + 4'h1;
      if (s.tx_bits == (s.tx_ctl[usr_pkg::BIT_NINE_TX_EN] ? 4'h8 : 4'h7)) begin
        next_s.tsr_busy = 1'b0;
      end
    end

    // Pin ownership: sync select and port enable; the clock pin also needs master clock
    next_s.ck_pin.oe = port_en & sync_mode & clk_master & (tx_en | rx_mode);
    next_s.ck_pin.o = next_s.sclk;
    // Data pin released while receiving; transmitter kept
    next_s.dt_pin.oe = port_en & sync_mode & tx_en & ~rx_mode;

    // FIFO pop on buffer read; status follows next entry
    pop = bus_req.rd && hit(bus_req.addr, usr_pkg::ADDR_RX_BUFFER) && (s.fifo_cnt != 2'h0);

    // Register writes
    if (bus_req.wr) begin
      if (hit(bus_req.addr, usr_pkg::ADDR_IRQ_ENABLES)) begin
        next_s.irq_en = bus_req.wdata;
      end
      if (hit(bus_req.addr, usr_pkg::ADDR_RX_STATUS)) begin
        next_s.rx_ctl = bus_req.wdata & 8'hf0;
        if (!bus_req.wdata[usr_pkg::BIT_CONT_RX_EN]) begin
          // An overrun raised in this same cycle keeps its flag
          next_s.overrun = next_s.overrun & ~s.overrun;  // Receive reset
          next_s.rx_state = RX_IDLE;
        end
      end
      if (hit(bus_req.addr, usr_pkg::ADDR_TX_STATUS)) begin
        next_s.tx_ctl = bus_req.wdata & 8'hf5;
        if (bus_req.wdata[usr_pkg::BIT_TX_EN] && !tx_en) begin
          next_s.tx_empty_flag = ~s.tx_buf_full;
        end
      end
      if (hit(bus_req.addr, usr_pkg::ADDR_BAUD_DIV)) begin
        next_s.baud_div = bus_req.wdata;
        next_s.brg_cnt = 8'h00;
      end
      if (hit(bus_req.addr, usr_pkg::ADDR_TX_BUFFER)) begin
        next_s.tx_buf = bus_req.wdata;
        next_s.tx_buf_full = 1'b1;
        next_s.tx_empty_flag = 1'b0;  // Cleared by a buffer write, or by a transmit enable write while the buffer is full
      end
    end

    // FIFO update
    if (push) begin
      next_s.fifo[s.fifo_rd_ptr ^ (s.fifo_cnt != 2'h0)] = word;
    end
    if (pop) begin
      next_s.fifo_rd_ptr = ~s.fifo_rd_ptr;
    end
    next_s.fifo_cnt = s.fifo_cnt + {1'b0, push} - {1'b0, pop};

    // Read data, one cycle later; flag and shifter bits are read-only
    word = s.fifo[s.fifo_rd_ptr];
    tx_stat = s.tx_ctl;
    tx_stat[usr_pkg::BIT_SHIFTER_EMPTY] = ~s.tsr_busy;
    rx_stat = s.rx_ctl;
    rx_stat[usr_pkg::BIT_OVERRUN] = s.overrun;
    rx_stat[usr_pkg::BIT_FRAMING] = (s.fifo_cnt != 2'h0) & word.framing;
    rx_stat[usr_pkg::BIT_RX_NINTH] = (s.fifo_cnt != 2'h0) & word.ninth;
    flags = 8'h00;
    flags[usr_pkg::BIT_RX_AVAIL] = s.fifo_cnt != 2'h0;
    flags[usr_pkg::BIT_TX_EMPTY] = s.tx_empty_flag;
    next_s.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        usr_pkg::ADDR_IRQ_FLAGS:   next_s.rdata = flags;
        usr_pkg::ADDR_RX_STATUS:   next_s.rdata = rx_stat;
        usr_pkg::ADDR_TX_BUFFER:   next_s.rdata = s.tx_buf;
        usr_pkg::ADDR_RX_BUFFER:   next_s.rdata = (s.fifo_cnt != 2'h0) ? word.data : 8'h00;
        usr_pkg::ADDR_IRQ_ENABLES: next_s.rdata = s.irq_en;
        usr_pkg::ADDR_TX_STATUS:   next_s.rdata = tx_stat;
        usr_pkg::ADDR_BAUD_DIV:    next_s.rdata = s.baud_div;
        default:                   next_s.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset values are constants only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.irq_en <= usr_pkg::RST_IRQ_ENABLES;
      s.rx_ctl <= usr_pkg::RST_RX_STATUS;
      s.tx_ctl <= usr_pkg::RST_TX_STATUS & 8'hf5;
      s.baud_div <= usr_pkg::RST_BAUD_DIV;
      s.tx_buf <= usr_pkg::RST_TX_BUFFER;
      s.rx_sync <= 2'h3;  // Line idles high
      s.rx_state <= RX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs from flip-flops; interrupts are flag and enable
  logic rx_irq_q;
  logic tx_irq_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_irq_q <= 1'b0;
      tx_irq_q <= 1'b0;
    end else begin
      rx_irq_q <= (next_s.fifo_cnt != 2'h0) & next_s.irq_en[usr_pkg::BIT_RX_AVAIL];
      tx_irq_q <= next_s.tx_empty_flag & next_s.irq_en[usr_pkg::BIT_TX_EMPTY];
    end
  end

  assign bus_rdata             = s.rdata;
  assign transmit_or_clock_pin = s.ck_pin;
  assign receive_or_data_pin   = s.dt_pin;
  assign receive_irq           = rx_irq_q;
  assign transmit_irq          = tx_irq_q;

endmodule

// [test/usr_checker.sv]
// Checker for the serial port: bus, interrupt and pin relations.
// Assumes binding to usr_top; control bits are shadowed from bus writes.
`timescale 1ns/1ps
module usr_checker (
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  nrst,
  // Register port
  input wire usr_pkg::usr_bus_req_t bus_req,
  input wire logic [7:0]            bus_rdata,
  // Pins
  input wire logic                  transmit_or_clock_pin_i,
  input wire usr_pkg::usr_pin_t     transmit_or_clock_pin,
  input wire logic                  receive_or_data_pin_i,
  input wire usr_pkg::usr_pin_t     receive_or_data_pin,
  // Interrupt requests
  input wire logic                  receive_irq,
  input wire logic                  transmit_irq
);
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] ie_q;
  wire logic  ck_en = rx_q[7] & tx_q[7] & tx_q[4];
  // Shadow of what software wrote; hardware-cleared bits are not tracked
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      ie_q <= 8'h00;
    end else if (bus_req.wr) begin
      if (bus_req.addr == usr_pkg::ADDR_RX_STATUS) rx_q <= bus_req.wdata;
      if (bus_req.addr == usr_pkg::ADDR_TX_STATUS) tx_q <= bus_req.wdata;
      if (bus_req.addr == usr_pkg::ADDR_IRQ_ENABLES) ie_q <= bus_req.wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_tx_off;
    bus_req.wr && bus_req.addr == usr_pkg::ADDR_TX_STATUS && !bus_req.wdata[5]
      && !rx_q[4] && !rx_q[5];
  endsequence
  sequence s_pins_free;
    !transmit_or_clock_pin.oe && !receive_or_data_pin.oe;
  endsequence
  a_rdata_quiet: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside a read cycle");
  a_rx_irq_gate: assert property (receive_irq |-> ie_q[5] || $past(ie_q[5]))
    else $error("receive request without its enable");
  a_tx_irq_gate: assert property (transmit_irq |-> ie_q[4] || $past(ie_q[4]))
    else $error("transmit request without its enable");
  a_abort_release: assert property (s_tx_off |-> ##[1:3] s_pins_free)
    else $error("pins still driven after transmit disable");
  a_rx_takes_data: assert property (bus_req.wr && bus_req.addr == usr_pkg::ADDR_RX_STATUS
    && bus_req.wdata[4] |-> ##[1:3] !receive_or_data_pin.oe)
    else $error("data pin kept after receive enable");
  a_half_duplex: assert property (receive_or_data_pin.oe && rx_q[4] |-> !$past(rx_q[4], 3))
    else $error("data driven while receiving");
  a_data_steady: assert property ($fell(transmit_or_clock_pin.o) && receive_or_data_pin.oe
    && $past(receive_or_data_pin.oe) |-> $stable(receive_or_data_pin.o))
    else $error("data moved at falling shift clock");
  a_clock_gated: assert property (transmit_or_clock_pin.oe |-> ck_en || $past(ck_en))
    else $error("clock pin driven outside master sync mode");
  // Bench keeps the divisor at zero in sync mode: two cycles high
  a_clock_rate: assert property ($rose(transmit_or_clock_pin.o) && transmit_or_clock_pin.oe
    |-> ##1 (transmit_or_clock_pin.o || !transmit_or_clock_pin.oe)
    ##1 (!transmit_or_clock_pin.o || !transmit_or_clock_pin.oe))
    else $error("shift clock high time wrong");
endmodule

// [test/usr_line_model.sv]
// Far-end device: sends async frames, collects words clocked out in sync.
// Assumes the receive line idles high through a pull-up.
`timescale 1ns/1ps
module usr_line_model #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input wire logic              core_clk,
  // Pins of the port
  input wire usr_pkg::usr_pin_t ck_pin,
  input wire usr_pkg::usr_pin_t dt_pin,
  output logic                  ck_level,
  output logic                  dt_level
);
  logic       line = 1'b1;
  logic       ck_prev = 1'b0;
  logic [7:0] sh = 8'h00;
  int         nbits = 0;
  logic [7:0] got[$];
  // Undriven clock floats to the pull-up level; undriven data follows the far-end line
  assign ck_level = ck_pin.oe ? ck_pin.o : 1'b1;
  assign dt_level = dt_pin.oe ? dt_pin.o : line;
  // Start, eight data bits LSB first, stop at the given level, idle bit
  task automatic send(input logic [7:0] d, input logic stop_lvl);
    logic [10:0] f;
    f = {1'b1, stop_lvl, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge core_clk);
      line <= f[i];
      repeat (BIT_CYC - 1) @(posedge core_clk);
    end
  endtask
  task automatic flush();
    got.delete();
    nbits = 0;
  endtask
  // Sample data at each falling shift clock, LSB first
  always @(posedge core_clk) begin
    ck_prev <= ck_pin.oe & ck_pin.o;  // The pull-up is no clock edge
    if (ck_prev && ck_pin.oe && !ck_pin.o && dt_pin.oe) begin
      sh = {dt_pin.o, sh[7:1]};
      nbits = nbits + 1;
      if (nbits == 8) begin
        got.push_back(sh);
        nbits = 0;
      end
    end
  end
endmodule

// [test/usr_top_bench.sv]
// Bench for the serial port: registers, async receive, sync master send.
// Assumes usr_top, usr_line_model and usr_checker are compiled first.
`timescale 1ns/1ps
module usr_top_bench;
  localparam logic [7:0] RA [8] = '{8'h0c, 8'h18, 8'h19, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h20};
  localparam logic [7:0] RV [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  logic                  core_clk = 1'b0;
  logic                  nrst = 1'b0;
  usr_pkg::usr_bus_req_t bus_req = '0;
  logic [7:0]            bus_rdata;
  usr_pkg::usr_pin_t     ck_pin;
  usr_pkg::usr_pin_t     dt_pin;
  logic                  ck_level;
  logic                  dt_level;
  logic                  receive_irq;
  logic                  transmit_irq;
  int                    mismatches = 0;
  int                    cmp_count = 0;
  // 20 MHz core clock
  always #25 core_clk = ~core_clk;
  usr_top DUT (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .transmit_or_clock_pin_i(ck_level), .transmit_or_clock_pin(ck_pin),
    .receive_or_data_pin_i(dt_level), .receive_or_data_pin(dt_pin),
    .receive_irq(receive_irq), .transmit_irq(transmit_irq));
  usr_line_model #(.BIT_CYC(16)) far (.core_clk(core_clk), .ck_pin(ck_pin),
    .dt_pin(dt_pin), .ck_level(ck_level), .dt_level(dt_level));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                    input string what);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(what, e & m, bus_rdata & m);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Whole run needs about 1300 cycles; cut a hang at 40000
  initial begin
    #2_000_000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) rd(RA[i], RV[i], 8'hff, "reset value");
    wr(8'h99, 8'h5a);
    rd(8'h99, 8'h5a, 8'hff, "divisor");
    wr(8'h99, 8'h00);
    wr(8'h8c, 8'h30);
    rd(8'h8c, 8'h30, 8'hff, "enables");
    $display("test registers done");
    // Async receive: fill FIFO, framing entry, overrun, recovery
    wr(8'h98, 8'h04);
    wr(8'h18, 8'h80);
    rd(8'h98, 8'h06, 8'hff, "tx status");
    far.send(8'h11, 1'b1);
    rd(8'h0c, 8'h00, 8'h20, "avail off");
    wr(8'h18, 8'h90);
    far.send(8'ha5, 1'b1);
    chk("rx irq", 8'h01, {7'h00, receive_irq});
    far.send(8'h3c, 1'b0);
    far.send(8'h5a, 1'b1);
    rd(8'h0c, 8'h20, 8'h20, "avail");
    rd(8'h18, 8'h92, 8'hff, "rx status");
    rd(8'h1a, 8'ha5, 8'hff, "word 1");
    rd(8'h18, 8'h96, 8'hff, "rx status");
    rd(8'h1a, 8'h3c, 8'hff, "word 2");
    rd(8'h0c, 8'h00, 8'h20, "avail");
    far.send(8'h77, 1'b1);
    rd(8'h0c, 8'h00, 8'h20, "blocked");
    wr(8'h18, 8'h80);
    wr(8'h18, 8'h90);
    rd(8'h18, 8'h90, 8'hff, "rx status");
    far.send(8'h81, 1'b1);
    rd(8'h1a, 8'h81, 8'hff, "word 3");
    $display("test async receive done");
    // Sync master send, two words back to back
    wr(8'h18, 8'h00);
    far.flush();
    wr(8'h98, 8'hb0);
    wr(8'h18, 8'h80);
    wr(8'h19, 8'h96);
    wr(8'h19, 8'h3f);
    rd(8'h0c, 8'h00, 8'h10, "tx empty");
    for (int i = 0; i < 300 && far.got.size() < 2; i++) @(posedge core_clk);
    chk("count", 8'h02, 8'(far.got.size()));
    chk("sent a", 8'h96, far.got[0]);
    chk("sent b", 8'h3f, far.got[1]);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'h10, 8'h10, "tx empty");
    chk("tx irq", 8'h01, {7'h00, transmit_irq});
    rd(8'h98, 8'hb2, 8'hff, "tx status");
    $display("test sync send done");
    // Abort by transmit disable, then data pin release by receive enable
    wr(8'h19, 8'hc3);
    repeat (6) @(posedge core_clk);
    wr(8'h98, 8'h90);
    repeat (3) @(posedge core_clk);
    chk("pins oe", 8'h00, {6'h00, ck_pin.oe, dt_pin.oe});
    wr(8'h98, 8'hb0);
    wr(8'h19, 8'h0f);
    repeat (6) @(posedge core_clk);
    wr(8'h18, 8'h90);
    repeat (3) @(posedge core_clk);
    chk("pins oe", 8'h02, {6'h00, ck_pin.oe, dt_pin.oe});
    wr(8'h98, 8'h90);
    $display("test abort done");
    // Single sync receive of the idle-high line, then the enable drops
    wr(8'h18, 8'ha0);
    repeat (60) @(posedge core_clk);
    rd(8'h18, 8'h80, 8'hff, "single done");
    rd(8'h1a, 8'hff, 8'hff, "single word");
    $display("test single receive done");
    tally_and_finish();
  end
endmodule
bind usr_top usr_checker CHK (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .transmit_or_clock_pin_i(transmit_or_clock_pin_i),
  .transmit_or_clock_pin(transmit_or_clock_pin), .receive_or_data_pin_i(receive_or_data_pin_i),
  .receive_or_data_pin(receive_or_data_pin), .receive_irq(receive_irq),
  .transmit_irq(transmit_irq));
